// ==== core/nch_pkg.sv ====
// Shared types, commands and timing constants of the NAND column-pointer host controller.
package nch_pkg;

  // ==========================================================================
  // Request and pin types
  // ==========================================================================
  typedef enum logic [1:0] {NCH_OP_READ, NCH_OP_PROG, NCH_OP_ERASE, NCH_OP_RESET} nch_op_e;
  typedef enum logic [1:0] {NCH_AREA_A, NCH_AREA_B, NCH_AREA_C} nch_area_e;

  typedef struct packed {
    nch_op_e    op;
    nch_area_e  area;
    logic [7:0] col;
    logic [16:0] row;
    logic [9:0] len;
  } nch_req_s;

  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       ce_n;
    logic       we_n;
    logic       rd_strobe_n;
    logic [7:0] io_out;
    logic       io_oe;
  } nch_pins_s;

  typedef struct packed {
    logic       done;
    logic       fail;
    logic       refused;
    logic [7:0] rd_data;
    logic       rd_valid;
  } nch_resp_s;

  localparam nch_pins_s PINS_RST = '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, rd_strobe_n: 1'b1,
                                     io_out: 8'h00, io_oe: 1'b0};

  // ==========================================================================
  // Command codes and array layout
  // ==========================================================================
  localparam logic [7:0] CMD_PTR_A   = 8'h00;
  localparam logic [7:0] CMD_PTR_B   = 8'h01;
  localparam logic [7:0] CMD_PTR_C   = 8'h50;
  localparam logic [7:0] CMD_LOAD    = 8'h80;
  localparam logic [7:0] CMD_PROG    = 8'h10;
  localparam logic [7:0] CMD_ERASE1  = 8'h60;
  localparam logic [7:0] CMD_ERASE2  = 8'hd0;
  localparam logic [7:0] CMD_STATUS  = 8'h70;
  localparam logic [7:0] CMD_RESET   = 8'hff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int         MARK_COLUMN = 517;
  localparam int         SPARE_BASE  = 512;
  localparam logic [7:0] MARK_COL    = 8'(MARK_COLUMN - SPARE_BASE);
  localparam int         STAT_FAIL_BIT = 0;
  localparam int         PAGE_BITS   = 5;
  localparam int         NBLK        = 4096;

  // ==========================================================================
  // Timing, in ns and in mclk cycles
  // ==========================================================================
  localparam int CLK_NS    = 10;
  localparam int T_WP_NS   = 35;
  localparam int T_WH_NS   = 25;
  localparam int T_REA_NS  = 35;
  localparam int T_REH_NS  = 25;
  localparam int T_WB_NS   = 100;
  localparam int T_WHR_NS  = 60;
  localparam int T_CEH_NS  = 100;
  localparam int SYNC_LAT  = 4;
  localparam logic [7:0] WE_LOW_CYC  = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WE_HIGH_CYC = 8'((T_WH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WR_END      = WE_LOW_CYC + WE_HIGH_CYC;
  localparam logic [7:0] RE_LOW_CYC  = 8'((T_REA_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT);
  localparam logic [7:0] RE_HIGH_CYC = 8'((T_REH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RD_END      = RE_LOW_CYC + RE_HIGH_CYC;
  localparam logic [7:0] WB_CYC      = 8'((T_WB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WHR_CYC     = 8'((T_WHR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] CEH_CYC     = 8'(T_CEH_NS / CLK_NS + 1);

  // Pointer command that selects a column area.
  function automatic logic [7:0] nch_area_cmd(nch_area_e a);
    case (a)
      NCH_AREA_B: nch_area_cmd = CMD_PTR_B;
      NCH_AREA_C: nch_area_cmd = CMD_PTR_C;
      default:    nch_area_cmd = CMD_PTR_A;
    endcase
  endfunction

endpackage

// ==== core/nch_host.sv ====
// Host controller for an asynchronous 8-bit NAND flash, with its write FIFO and pin synchronisers.
`timescale 1ns/1ps

// ============================================================================
// Write data FIFO
// ============================================================================
module nch_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] DEPTH = (AW + 1)'(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                rdy;
    logic                vld;
  } nch_fifo_s;
  nch_fifo_s r, n;
  logic push, pop;

  // Push and pop update pointers; ready and valid are registered from the next count.
  always_comb begin
    n = r;
    push = in_valid && r.rdy;
    pop = out_ready && r.vld;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp = (r.wp == AW'(D - 1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(D - 1)) ? '0 : r.rp + 1'b1;
    end
    n.cnt = r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    n.rdy = n.cnt != DEPTH;
    n.vld = n.cnt != '0;
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      r <= '0;
      r.rdy <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign in_ready = r.rdy;
  assign out_valid = r.vld;
  assign out_data = r.mem[r.rp];
endmodule

// ============================================================================
// Pin synchroniser: three stages, accepted when the last two agree
// ============================================================================
module nch_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } nch_sync_s;
  nch_sync_s r, n;

  // Shift the pin through the stages and filter on agreement.
  always_comb begin
    n = r;
    n.s1 = d;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) begin
      n.q = r.s3;
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.q;
endmodule

// ============================================================================
// Host controller
// ============================================================================
// Operation
// - Issue 00h or 50h before 80h to program from area A or C.
// - Issue 01h directly before 80h to program from area B.
// - Column 517 of pages 0 and 1 not all ones marks the block invalid.
// - Never erase the invalid-block mark; mask invalid blocks out.
// - On program or erase failure, report it and bar the failing block; a block 0 failure is reported but never barred.
// - Correct single-bit read errors by code, do not retire the block; the controller does no correction and leaves it to the user's ECC.
// - End a sequential read by holding chip select high over 100 ns.
// - With chip select toggled while loading, keep 10 ns setup.
// - Sample read data over 45 ns after chip select falls.
// - Write strobe low at least 35 ns when chip select setup is under 10 ns.
// - Program is 80h, four address cycles, data, 10h; no data means no program.
module nch_host (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire nch_pkg::nch_req_s    req,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic [7:0]           wr_data,
  input  wire logic                 wr_valid,
  output logic                      wr_ready,
  output nch_pkg::nch_resp_s        resp,
  output nch_pkg::nch_area_e        cur_area,
  output nch_pkg::nch_pins_s        pins,
  input  wire logic [7:0]           io_in,
  input  wire logic                 rb_n
);
  typedef enum {S_IDLE, S_PTR, S_CMD, S_ADDR, S_LOAD, S_DATA, S_CONF, S_WB, S_RB, S_RD, S_STAT, S_WHR,
                S_SRD, S_CEH} nch_st_e;
  typedef struct packed {
    nch_st_e              st;
    logic [7:0]           cnt;
    logic [9:0]           left;
    logic [1:0]           acnt;
    nch_pkg::nch_req_s    req;
    nch_pkg::nch_area_e   ptr;
    nch_pkg::nch_pins_s   pin;
    nch_pkg::nch_resp_s   rsp;
    logic                 idle;
    logic [nch_pkg::NBLK-1:0] bad;
  } nch_host_s;
  nch_host_s r, n;
  logic       pop, f_valid, rb_f;
  logic [7:0] f_data, io_f;
  logic [11:0] blk;

  nch_fifo #(.W(8), .D(4)) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_data   (wr_data),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (pop)
  );
  nch_sync #(.W(8)) u_sync_io (.mclk(mclk), .rst(rst), .d(io_in), .q(io_f));
  nch_sync #(.W(1)) u_sync_rb (.mclk(mclk), .rst(rst), .d(rb_n), .q(rb_f));

  assign blk = r.req.row[nch_pkg::PAGE_BITS +: 12];

  // Begin one write cycle with the given byte and latch enables.
  function automatic nch_host_s start_wr(nch_host_s s, nch_st_e st, logic [7:0] b, logic c, logic a);
    nch_host_s t;
    t = s;
    t.st = st;
    t.cnt = 8'h00;
    t.pin.io_out = b;
    t.pin.io_oe = 1'b1;
    t.pin.cle = c;
    t.pin.ale = a;
    return t;
  endfunction

  // Address byte i: column, then three row bytes.
  function automatic logic [7:0] addr_byte(nch_pkg::nch_req_s q, logic [1:0] i);
    case (i)
      2'd0:    addr_byte = q.col;
      2'd1:    addr_byte = q.row[7:0];
      2'd2:    addr_byte = q.row[15:8];
      default: addr_byte = {7'h00, q.row[16]};
    endcase
  endfunction

  // Sequencer: pointer, command, address, data, confirm, busy wait, status, chip select release.
  always_comb begin
    logic wr_st, rd_st, wr_end, rd_end, smp;
    wr_st = r.st inside {S_PTR, S_CMD, S_ADDR, S_DATA, S_CONF, S_STAT};
    rd_st = r.st inside {S_RD, S_SRD};
    wr_end = wr_st && r.cnt == nch_pkg::WR_END;
    rd_end = rd_st && r.cnt == nch_pkg::RD_END;
    smp = rd_st && r.cnt == nch_pkg::RE_LOW_CYC;
    n = r;
    pop = 1'b0;
    n.rsp.done = 1'b0;
    n.rsp.rd_valid = 1'b0;
    n.cnt = r.cnt + 8'h01;
    n.pin.we_n = !(wr_st && r.cnt < nch_pkg::WE_LOW_CYC);
    n.pin.rd_strobe_n = !(rd_st && r.cnt < nch_pkg::RE_LOW_CYC);
    case (r.st)
      S_IDLE: begin
        n.cnt = 8'h00;
        if (req_valid) begin
          n.req = req;
          n.left = req.len;
          n.idle = 1'b0;
          n.rsp.fail = 1'b0;
          n.rsp.refused = 1'b0;
          if ((req.op == nch_pkg::NCH_OP_PROG && req.len == 10'd0)
              || (req.op inside {nch_pkg::NCH_OP_PROG, nch_pkg::NCH_OP_ERASE}
                  && n.bad[req.row[nch_pkg::PAGE_BITS +: 12]])) begin
            n.rsp.refused = 1'b1;
            n.st = S_CEH;
          end else begin
            n.pin.ce_n = 1'b0;
            case (req.op)
              nch_pkg::NCH_OP_ERASE: n = start_wr(n, S_CMD, nch_pkg::CMD_ERASE1, 1'b1, 1'b0);
              nch_pkg::NCH_OP_RESET: n = start_wr(n, S_CMD, nch_pkg::CMD_RESET, 1'b1, 1'b0);
              default: n = start_wr(n, S_PTR, nch_pkg::nch_area_cmd(req.area), 1'b1, 1'b0);
            endcase
          end
        end
      end
      S_PTR: begin
        if (wr_end) begin
          n.ptr = r.req.area;
          if (r.req.op == nch_pkg::NCH_OP_PROG) begin
            n = start_wr(n, S_CMD, nch_pkg::CMD_LOAD, 1'b1, 1'b0);
          end else begin
            n = start_wr(n, S_ADDR, r.req.col, 1'b0, 1'b1);
            n.acnt = 2'd0;
          end
        end
      end
      S_CMD: begin
        if (wr_end) begin
          if (r.req.op == nch_pkg::NCH_OP_RESET) begin
            n.st = S_WB;
            n.cnt = 8'h00;
          end else begin
            n.acnt = (r.req.op == nch_pkg::NCH_OP_ERASE) ? 2'd1 : 2'd0;
            n = start_wr(n, S_ADDR, addr_byte(r.req, n.acnt), 1'b0, 1'b1);
          end
        end
      end
      S_ADDR: begin
        if (wr_end) begin
          if (r.acnt != 2'd3) begin
            n.acnt = r.acnt + 2'd1;
            n = start_wr(n, S_ADDR, addr_byte(r.req, n.acnt), 1'b0, 1'b1);
          end else if (r.req.op == nch_pkg::NCH_OP_PROG) begin
            n.st = S_LOAD;
            n.pin.ale = 1'b0;
          end else if (r.req.op == nch_pkg::NCH_OP_ERASE) begin
            n = start_wr(n, S_CONF, nch_pkg::CMD_ERASE2, 1'b1, 1'b0);
          end else begin
            n.st = S_WB;
            n.cnt = 8'h00;
            n.pin.ale = 1'b0;
          end
        end
      end
      S_LOAD: begin
        // Chip select stays low while the FIFO runs dry; the page buffer holds its bytes.
        if (f_valid) begin
          pop = 1'b1;
          n = start_wr(n, S_DATA, f_data, 1'b0, 1'b0);
        end
      end
      S_DATA: begin
        if (wr_end) begin
          n.left = r.left - 10'd1;
          if (r.left == 10'd1) begin
            n = start_wr(n, S_CONF, nch_pkg::CMD_PROG, 1'b1, 1'b0);
          end else begin
            n.st = S_LOAD;
          end
        end
      end
      S_CONF: begin
        if (wr_end) begin
          n.st = S_WB;
          n.cnt = 8'h00;
        end
      end
      S_WB: begin
        n.pin.cle = 1'b0;
        n.pin.io_oe = 1'b0;
        if (r.cnt == nch_pkg::WB_CYC) begin
          n.st = S_RB;
        end
      end
      S_RB: begin
        n.cnt = 8'h00;
        if (rb_f) begin
          case (r.req.op)
            nch_pkg::NCH_OP_READ:  n.st = S_RD;
            nch_pkg::NCH_OP_RESET: begin
              n.st = S_CEH;
              n.pin.ce_n = 1'b1;
            end
            default: n = start_wr(n, S_STAT, nch_pkg::CMD_STATUS, 1'b1, 1'b0);
          endcase
        end
      end
      S_RD: begin
        if (smp) begin
          n.rsp.rd_data = io_f;
          n.rsp.rd_valid = 1'b1;
          // Only the factory mark retires a block on read; data errors are left to the user's ECC.
          if (r.left == r.req.len && r.req.area == nch_pkg::NCH_AREA_C && r.req.col == nch_pkg::MARK_COL
              && r.req.row[nch_pkg::PAGE_BITS-1:1] == '0 && io_f != nch_pkg::ERASED_BYTE
              && blk != 12'h000) begin
            n.bad[blk] = 1'b1;
          end
        end
        if (rd_end) begin
          n.left = r.left - 10'd1;
          n.cnt = 8'h00;
          if (r.left == 10'd1) begin
            n.st = S_CEH;
            n.pin.ce_n = 1'b1;
          end
        end
      end
      S_STAT: begin
        if (wr_end) begin
          n.st = S_WHR;
          n.cnt = 8'h00;
        end
      end
      S_WHR: begin
        n.pin.cle = 1'b0;
        n.pin.io_oe = 1'b0;
        if (r.cnt == nch_pkg::WHR_CYC) begin
          n.st = S_SRD;
          n.cnt = 8'h00;
        end
      end
      S_SRD: begin
        if (smp) begin
          n.rsp.fail = io_f[nch_pkg::STAT_FAIL_BIT];
          if (io_f[nch_pkg::STAT_FAIL_BIT] && blk != 12'h000) begin
            n.bad[blk] = 1'b1;
          end
        end
        if (rd_end) begin
          n.st = S_CEH;
          n.cnt = 8'h00;
          n.pin.ce_n = 1'b1;
        end
      end
      S_CEH: begin
        n.pin.io_oe = 1'b0;
        if (r.cnt == nch_pkg::CEH_CYC) begin
          n.st = S_IDLE;
          n.idle = 1'b1;
          n.rsp.done = 1'b1;
          if (n.ptr == nch_pkg::NCH_AREA_B) begin
            n.ptr = nch_pkg::NCH_AREA_A;
          end
        end
      end
      default: n.st = S_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      r <= '0;
      r.pin <= nch_pkg::PINS_RST;
      r.idle <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign req_ready = r.idle;
  assign resp = r.rsp;
  assign cur_area = r.ptr;
  assign pins = r.pin;

  // Helper state: last command latched and length of the chip select high stretch.
  logic [7:0] last_cmd, ce_hi;
  always_ff @(posedge mclk) begin
    if (rst) begin
      last_cmd <= 8'h00;
      ce_hi <= 8'hff; // Chip select stays high through reset, so the first select follows a long break.
    end else begin
      if (r.pin.cle && !r.pin.we_n && n.pin.we_n) begin
        last_cmd <= r.pin.io_out;
      end
      ce_hi <= !r.pin.ce_n ? 8'h00 : (ce_hi == 8'hff ? ce_hi : ce_hi + 8'h01);
    end
  end

  a_ptr_revert: assert property (@(posedge mclk) disable iff (rst)
    r.rsp.done && !r.rsp.refused && r.req.area == nch_pkg::NCH_AREA_B
    && r.req.op inside {nch_pkg::NCH_OP_READ, nch_pkg::NCH_OP_PROG} |-> r.ptr == nch_pkg::NCH_AREA_A)
    else $error("Pointer did not return to area A.");
  a_ptr_persist: assert property (@(posedge mclk) disable iff (rst)
    r.rsp.done && !r.rsp.refused && r.req.area != nch_pkg::NCH_AREA_B
    && r.req.op inside {nch_pkg::NCH_OP_READ, nch_pkg::NCH_OP_PROG} |-> r.ptr == r.req.area)
    else $error("Pointer lost its area.");
  a_load_after_ptr: assert property (@(posedge mclk) disable iff (rst)
    $rose(r.pin.we_n) && r.pin.cle && r.pin.io_out == nch_pkg::CMD_LOAD
    |-> $past(last_cmd) == nch_pkg::nch_area_cmd(r.req.area))
    else $error("Load command not preceded by its pointer command.");
  a_we_width: assert property (@(posedge mclk) disable iff (rst)
    $fell(r.pin.we_n) |-> (!r.pin.we_n)[*4])
    else $error("Write strobe low pulse too short.");
  a_ce_gap: assert property (@(posedge mclk) disable iff (rst)
    $fell(r.pin.ce_n) |-> $past(ce_hi) > 8'd10)
    else $error("Chip select high time too short.");
  a_no_empty_prog: assert property (@(posedge mclk) disable iff (rst)
    r.pin.cle && $fell(r.pin.we_n) && r.pin.io_out == nch_pkg::CMD_PROG |-> r.req.len != 10'd0 && r.left == 10'd0 ##0 1)
    else $error("Program confirm without loaded data.");
  a_blk0_valid: assert property (@(posedge mclk) disable iff (rst)
    !r.bad[0])
    else $error("Block 0 marked invalid.");
  a_no_erase_bad: assert property (@(posedge mclk) disable iff (rst)
    r.st == S_CMD && r.req.op == nch_pkg::NCH_OP_ERASE |-> !r.bad[blk])
    else $error("Erase issued to an invalid block.");
  a_bad_on_fail: assert property (@(posedge mclk) disable iff (rst)
    r.rsp.done && r.rsp.fail && blk != 12'h000 |-> r.bad[blk])
    else $error("Failing block not barred.");
endmodule

// ==== tb/nch_flash_model.sv ====
// Behavioural NAND flash device that answers the host controller's pins.
`timescale 1ns/1ps

// ============================================================================
// Flash device model
// ============================================================================
module nch_flash_model #(
  parameter int T_R_NS    = 10000,
  parameter int T_PROG_NS = 20000,
  parameter int T_RST_NS  = 5000,
  parameter int BAD_A     = 96,
  parameter int BAD_B     = 129
) (
  input  wire nch_pkg::nch_pins_s pins,
  input  wire logic               fail_inject,
  output logic [7:0]              io_in,
  output logic                    rb_n
);
  logic [7:0]  mem [int];
  logic [7:0]  dq;
  logic [7:0]  mode;
  logic [1:0]  ptr;
  logic [16:0] row;
  logic        loaded;
  logic        fail_r;
  int          acnt;
  int          col;

  function automatic int key(logic [16:0] r, int c);
    key = int'(r) * 528 + c;
  endfunction

  // Drop ready for the given time; the array is busy meanwhile.
  task automatic busy(int t);
    rb_n = 1'b0;
    #(t);
    rb_n = 1'b1;
  endtask

  // The host's drive wins while it enables its outputs.
  assign io_in = pins.io_oe ? pins.io_out : dq;

  // Power-up state; block 0 carries no invalid mark.
  initial begin
    {dq, mode, ptr, row, loaded, fail_r, acnt, col} = '0;
    rb_n = 1'b1;
    mem[key(17'(BAD_A), 517)] = 8'h00; // Factory marks, all else erased.
    mem[key(17'(BAD_B), 517)] = 8'h3c;
  end

  // Latch command, address and data on the rising write strobe.
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.cle) begin
      mode = pins.io_out;
      acnt = 0; // Every command restarts the address count.
      case (pins.io_out)
        8'h00, 8'h01: ptr = pins.io_out[1:0]; // Pointer set; area B lasts one operation.
        8'h50: ptr = 2'd2; // Spare area pointer.
        8'h80: loaded = 1'b0;
        8'h60: acnt = 1;
        8'h10: if (loaded) begin // Confirm alone starts nothing.
          fail_r = fail_inject;
          fork busy(T_PROG_NS); join_none
          if (ptr == 2'd1) ptr = 2'd0; // Second half lasts one operation.
        end
        8'hd0: begin
          for (int i = 0; i < 16896; i++) mem[key({row[16:5], 5'h00}, i)] = 8'hff;
          fail_r = fail_inject;
          fork busy(T_PROG_NS); join_none
          if (ptr == 2'd1) ptr = 2'd0;
        end
        8'hff: begin
          fork busy(T_RST_NS); join_none // Reset from ready.
          if (ptr == 2'd1) ptr = 2'd0;
        end
        default: ;
      endcase
    end else if (!pins.ce_n && pins.ale) begin
      case (acnt)
        0: col = 256 * int'(ptr) + int'(pins.io_out);
        1: row[7:0] = pins.io_out;
        2: row[15:8] = pins.io_out;
        default: row[16] = pins.io_out[0];
      endcase
      acnt++;
      if (acnt == 4 && mode != 8'h80 && mode != 8'h60) begin
        fork busy(T_R_NS); join_none // Page to buffer.
        if (ptr == 2'd1) ptr = 2'd0;
      end
    end else if (!pins.ce_n && mode == 8'h80) begin
      mem[key(row, col)] = pins.io_out; // Buffer loading.
      col++;
      loaded = 1'b1;
    end
  end

  // Present a byte or the status shortly after the read strobe falls.
  always @(negedge pins.rd_strobe_n) begin
    if (!pins.ce_n) begin
      #20;
      if (mode == 8'h70) dq = {1'b1, rb_n, 5'h00, fail_r};
      else dq = mem.exists(key(row, col)) ? mem[key(row, col)] : 8'hff;
      col++;
    end
  end

  // A released bus shows no stale byte.
  always @(posedge pins.rd_strobe_n) #15 dq = ~dq;

  // Reading past the page end loads the next page; busy follows the last strobe within 100 ns.
  always @(posedge pins.rd_strobe_n) begin
    if (!pins.ce_n && mode != 8'h70 && col == 528) begin
      row++;
      col = 0;
      #50 busy(T_R_NS);
    end
  end

  // Chip select raised during a page load aborts it; ready returns within 50 ns.
  always @(posedge pins.ce_n) begin
    if (!rb_n && mode inside {8'h00, 8'h01, 8'h50}) begin
      #40 rb_n = 1'b1;
    end
  end
endmodule

// ==== tb/nch_host_test.sv ====
// Self-checking bench of the NAND host controller against the flash device model.
`timescale 1ns/1ps

// ============================================================================
// Bench top
// ============================================================================
module nch_host_test;
  logic               mclk;
  logic               rst;
  nch_pkg::nch_req_s  req;
  logic               req_valid;
  logic               req_ready;
  logic [7:0]         wr_data;
  logic               wr_valid;
  logic               wr_ready;
  nch_pkg::nch_resp_s resp;
  nch_pkg::nch_area_e cur_area;
  nch_pkg::nch_pins_s pins;
  logic [7:0]         io_in;
  logic               rb_n;
  logic               fail_inject;
  logic [7:0]         ref_mem [int];
  logic [4095:0]      ref_bad;
  logic [1:0]         ref_area;
  logic [7:0]         q [$];
  int                 num_errors;
  int                 n_compared;
  int                 seed;
  int                 ce_hi;
  int                 we_lo;

  nch_host uut (.mclk(mclk), .rst(rst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .resp(resp), .cur_area(cur_area),
    .pins(pins), .io_in(io_in), .rb_n(rb_n));
  nch_flash_model dev (.pins(pins), .fail_inject(fail_inject), .io_in(io_in), .rb_n(rb_n));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  function automatic int key(logic [16:0] r, int c);
    key = int'(r) * 528 + c;
  endfunction

  task automatic check(logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Push one program byte with a random stall before it.
  task automatic push(logic [7:0] d);
    repeat (2'($random(seed))) @(negedge mclk);
    @(negedge mclk);
    while (!wr_ready) @(negedge mclk);
    wr_data = d;
    wr_valid = 1'b1;
    @(negedge mclk);
    wr_valid = 1'b0;
    q.push_back(d);
  endtask

  // Op codes 0 read, 1 program, 2 erase, 3 reset; areas 0 A, 1 B, 2 C.
  task automatic run(logic [1:0] op, logic [1:0] ar, logic [7:0] col, logic [16:0] row, int len);
    int   k0;
    int   n;
    int   blk;
    logic pe;
    logic nope;
    logic efail;
    k0 = key(row, 256 * int'(ar) + int'(col));
    blk = int'(row[16:5]);
    pe = op == 2'd1 || op == 2'd2;
    nope = (op == 2'd1 && len == 0) || (pe && ref_bad[blk]);
    efail = pe && !nope && fail_inject;
    @(negedge mclk);
    req = '{op: nch_pkg::nch_op_e'(op), area: nch_pkg::nch_area_e'(ar), col: col, row: row, len: 10'(len)};
    req_valid = 1'b1;
    while (!req_ready) @(negedge mclk);
    @(negedge mclk);
    req_valid = 1'b0;
    n = 0;
    for (int t = 0; t < 20000 && !resp.done; t++) begin
      if (resp.rd_valid === 1'b1) begin
        check(resp.rd_data, ref_mem.exists(k0 + n) ? ref_mem[k0 + n] : 8'hff); // Read data.
        n++;
      end
      @(negedge mclk);
    end
    check({resp.done, resp.refused, resp.fail, 10'(n)}, {1'b1, nope, efail, 10'(op == 2'd0 ? len : 0)});
    if (op == 2'd1 && !nope) for (int i = 0; i < len; i++) ref_mem[k0 + i] = q.pop_front();
    if (op == 2'd2 && !nope) for (int i = 0; i < 16896; i++) ref_mem[key({row[16:5], 5'h00}, i)] = 8'hff;
    if (efail && blk != 0) ref_bad[blk] = 1'b1;
    if (op == 2'd0 && ar == 2'd2 && col == 8'h05 && row[4:1] == 4'h0 && blk != 0 && ref_mem.exists(k0)
        && ref_mem[k0] !== 8'hff) ref_bad[blk] = 1'b1;
    if (!nope && op < 2'd2) ref_area = (ar == 2'd1) ? 2'd0 : ar;
    @(negedge mclk);
    check(16'(cur_area), 16'(ref_area)); // Pointer tracking.
  endtask

  // Watch chip-select high breaks and write strobe low widths.
  always @(posedge mclk) begin
    if (rst) begin
      ce_hi <= 20;
      we_lo <= 0;
    end else begin
      ce_hi <= pins.ce_n ? ce_hi + 1 : 0;
      we_lo <= pins.we_n ? 0 : we_lo + 1;
      if (!pins.ce_n && ce_hi > 0) check(16'(ce_hi > 10), 16'h0001); // Break over 100 ns.
      if (pins.we_n && we_lo > 0) check(16'(we_lo >= 4), 16'h0001); // Strobe low at least four cycles, 40 ns.
    end
  end

  // Cut a hung run short.
  initial begin
    #800000;
    num_errors++;
    stop_test();
  end

  // Main sequence.
  initial begin
    {num_errors, n_compared, ref_bad, ref_area} = '0;
    seed = 32'h3ae9e5b5;
    {req, req_valid, wr_data, wr_valid, fail_inject} = '0;
    rst = 1'b1;
    ref_mem[key(17'd96, 517)] = 8'h00;
    ref_mem[key(17'd129, 517)] = 8'h3c;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (4) push(8'($random(seed)));
    check(16'(wr_ready), 16'h0000); // A full buffer refuses more bytes.
    run(2'd1, 2'd0, 8'h0a, 17'h20, 4); // Drain by programming area A.
    run(2'd0, 2'd0, 8'h08, 17'h20, 8);
    for (int a = 0; a < 3; a++) begin
      fork
        repeat (6) push(8'($random(seed)));
        run(2'd1, 2'(a), 8'h03, 17'h40 + 17'(a), 6);
      join
      run(2'd0, 2'(a), 8'h01, 17'h40 + 17'(a), 10);
    end
    run(2'd1, 2'd0, 8'h00, 17'h21, 0); // Program without data.
    run(2'd0, 2'd2, 8'h05, 17'h60, 1);
    run(2'd0, 2'd2, 8'h05, 17'h81, 1);
    run(2'd2, 2'd0, 8'h00, 17'h60, 0);
    run(2'd1, 2'd0, 8'h00, 17'h81, 1);
    run(2'd2, 2'd0, 8'h00, 17'h40, 0);
    run(2'd0, 2'd1, 8'h00, 17'h41, 4);
    fail_inject = 1'b1;
    fork
      push(8'h5a);
      run(2'd1, 2'd2, 8'h02, 17'ha0, 1);
    join
    fail_inject = 1'b0;
    run(2'd2, 2'd0, 8'h00, 17'ha0, 0);
    run(2'd3, 2'd0, 8'h00, 17'h00, 0);
    stop_test();
  end
endmodule
